//--- hw/ssp_pkg.sv
// Purpose: constants shared by the synchronous serial port design
// Assumes: 32-bit AHB-Lite register bus, one register per aligned word
// Notes:   register offsets are byte addresses
`default_nettype none
package ssp_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_BAUD_CONTROL  = 8'h00;
   localparam logic [7:0] OFS_RECEIVE_DATA  = 8'h04;
   localparam logic [7:0] OFS_RX_STATUS     = 8'h08;
   localparam logic [7:0] OFS_DIV_LOW       = 8'h0C;
   localparam logic [7:0] OFS_DIV_HIGH      = 8'h10;
   localparam logic [7:0] OFS_TX_STATUS     = 8'h14;
   localparam logic [7:0] OFS_TX_HOLDING    = 8'h18;
   localparam logic [7:0] OFS_IRQ_CTRL      = 8'h1C;
   localparam logic [7:0] OFS_IRQ_FLAGS     = 8'h20;
   // ------------------------------------------------------------
   // receive_status_control fields
   // ------------------------------------------------------------
   localparam int RS_PORT_EN   = 7;
   localparam int RS_NINE_RX   = 6;
   localparam int RS_SINGLE    = 5;
   localparam int RS_CONT      = 4;
   localparam int RS_FRAME_ERR = 2;
   localparam int RS_OVERRUN   = 1;
   localparam int RS_NINTH     = 0;
   // ------------------------------------------------------------
   // transmit_status_control fields
   // ------------------------------------------------------------
   localparam int TS_CLK_MASTER = 7;
   localparam int TS_NINE_TX    = 6;
   localparam int TS_TX_EN      = 5;
   localparam int TS_SYNC       = 4;
   localparam int TS_SHIFT_IDLE = 1;
   localparam int TS_NINTH      = 0;
   // ------------------------------------------------------------
   // irq control: enables and sleep request
   // ------------------------------------------------------------
   localparam int IC_RX_IE    = 0;
   localparam int IC_TX_IE    = 1;
   localparam int IC_PERIPH   = 2;
   localparam int IC_GLOBAL   = 3;
   localparam int IC_SLEEP    = 4;
   localparam int IF_RX       = 0;
   localparam int IF_TX       = 1;
   // ------------------------------------------------------------
   // reset values and character lengths
   // ------------------------------------------------------------
   localparam logic [7:0] RST_TX_STATUS = 8'h02;
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [3:0] CHAR_BITS_8   = 4'h8;
   localparam logic [3:0] CHAR_BITS_9   = 4'h9;
endpackage
`default_nettype wire

//--- hw/ssp_edge_sync.sv
// Purpose: two-flop synchroniser of the serial clock pin with edge pulses
// Assumes: pin is asynchronous to hclk
// Notes:   first flop is read only by the second
`default_nettype none
module ssp_edge_sync (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic pin,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta;    // first stage only
   logic prev;    // last synchronised value

   // ------------------------------------------------------------
   // synchroniser and edge detect
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta  <= 1'b0;
         level <= 1'b0;
         prev  <= 1'b0;
      end else begin
         meta  <= pin;
         level <= meta;
         prev  <= level;
      end
   end

   assign rise = level & ~prev;
   assign fall = ~level & prev;
endmodule
`default_nettype wire

//--- hw/ssp_sync_port.sv
// Purpose: synchronous half-duplex serial port, master receive and slave rx/tx
// Assumes: AHB-Lite single word transfers, zero wait states, OKAY only
// Notes:   idle clock low; data changes on rising, sampled on falling edge
//
// The address map and register access over AHB-Lite were decided locally.
`default_nettype none
module ssp_sync_port (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        serial_clock_pin_i,
   output logic             serial_clock_pin_o,
   output logic             serial_clock_pin_oe_n,
   input  wire logic        serial_data_pin_i,
   output logic             serial_data_pin_o,
   output logic             serial_data_pin_oe_n,
   output logic             irq,
   output logic             wake
);
   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic [7:0]  baud_control;           // stored, no effect in sync mode
   logic [7:0]  rx_ctl;                 // enables of receive_status_control
   logic [7:0]  tx_ctl;                 // writable bits of transmit_status_control
   logic [15:0] divisor;                // baud divisor high:low
   logic [4:0]  irq_ctl;                // enables and sleep
   logic [8:0]  tx_hold;                // holding register with ninth bit
   logic        hold_full;              // holding register occupied
   logic [8:0]  tx_shift;               // transmit_shift_register
   logic [3:0]  tx_cnt;                 // bits left in transmit shift
   logic [8:0]  rx_shift;               // receive_shift_register
   logic [3:0]  rx_cnt;                 // bits gathered
   logic [8:0]  fifo [2];               // two-character receive buffer
   logic [1:0]  fifo_cnt;               // characters held
   logic        fifo_rd;                // read pointer
   logic        overrun;                // overrun_error_flag
   logic        tx_ready_flag;          // transmit_ready_flag
   // master clock generation
   logic [15:0] brg_cnt;
   logic        mclk;
   // bus data phase capture
   logic        ph_valid;
   logic        ph_write;
   logic [7:0]  ph_addr;

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   logic port_en, sync_mode, master, rx_mode, sleeping, clk_run;
   logic nine_rx, nine_tx, rx_full_char, active_sleep_ok;
   assign port_en   = rx_ctl[ssp_pkg::RS_PORT_EN];
   assign sync_mode = tx_ctl[ssp_pkg::TS_SYNC];
   assign master    = tx_ctl[ssp_pkg::TS_CLK_MASTER];
   assign sleeping  = irq_ctl[ssp_pkg::IC_SLEEP];
   // slave: single enable still selects receive, same as for a master
   assign rx_mode   = master ? (rx_ctl[ssp_pkg::RS_SINGLE] | rx_ctl[ssp_pkg::RS_CONT])
                             : (rx_ctl[ssp_pkg::RS_CONT] | rx_ctl[ssp_pkg::RS_SINGLE]);
   assign nine_rx   = rx_ctl[ssp_pkg::RS_NINE_RX];
   assign nine_tx   = tx_ctl[ssp_pkg::TS_NINE_TX];
   // only a slave keeps shifting while asleep
   assign active_sleep_ok = ~sleeping | ~master;
   assign clk_run   = port_en & sync_mode & active_sleep_ok;

   // ------------------------------------------------------------
   // serial clock: synchronised edges, slave or own master clock
   // ------------------------------------------------------------
   logic ext_lvl, ext_rise, ext_fall, lead, trail, mtick;
   ssp_edge_sync u_ck (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin     (serial_clock_pin_i),
      .level   (ext_lvl),
      .rise    (ext_rise),
      .fall    (ext_fall)
   );
   logic data_lvl, data_meta;
   // two flops before the data pin is read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_meta <= 1'b0;
         data_lvl  <= 1'b0;
      end else begin
         data_meta <= serial_data_pin_i;
         data_lvl  <= data_meta;
      end
   end

   // master clocks run only while a receive is wanted and no overrun is flagged
   logic m_want;
   assign m_want = clk_run & master & rx_mode & ~overrun;
   assign mtick  = m_want & (brg_cnt == divisor);

   // baud divider; slave ignores it entirely
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         brg_cnt <= 16'h0000;
         mclk    <= 1'b0;
      end else if (!m_want) begin
         brg_cnt <= 16'h0000;
         mclk    <= 1'b0;
      end else if (mtick) begin
         brg_cnt <= 16'h0000;
         mclk    <= ~mclk;
      end else begin
         brg_cnt <= brg_cnt + 16'h0001;
      end
   end
   assign lead  = master ? (mtick & ~mclk) : (clk_run & ext_rise);
   assign trail = master ? (mtick &  mclk) : (clk_run & ext_fall);

   // slave leaves the clock pin undriven
   assign serial_clock_pin_o    = mclk;
   assign serial_clock_pin_oe_n = ~(clk_run & master);

   // ------------------------------------------------------------
   // bus slave: address phase capture
   // ------------------------------------------------------------
   logic wr_hit, rd_hit;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr  <= 8'h00;
      end else if (hready) begin
         ph_valid <= hsel & htrans[1];
         ph_write <= hwrite;
         ph_addr  <= haddr;
      end
   end
   assign wr_hit = ph_valid & ph_write;
   assign rd_hit = ph_valid & ~ph_write;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   logic wr_rx, wr_tx, wr_hold, rd_data;
   assign wr_rx   = wr_hit & hit(ph_addr, ssp_pkg::OFS_RX_STATUS);
   assign wr_tx   = wr_hit & hit(ph_addr, ssp_pkg::OFS_TX_STATUS);
   assign wr_hold = wr_hit & hit(ph_addr, ssp_pkg::OFS_TX_HOLDING);
   // a read of receive_data pops the buffer
   assign rd_data = rd_hit & hit(ph_addr, ssp_pkg::OFS_RECEIVE_DATA) & (fifo_cnt != 2'd0);

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   logic rx_done, single_done;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         baud_control <= ssp_pkg::RST_ZERO;
         rx_ctl       <= ssp_pkg::RST_ZERO;
         tx_ctl       <= ssp_pkg::RST_ZERO;
         divisor      <= 16'h0000;
         irq_ctl      <= 5'h00;
      end else begin
         if (wr_hit && hit(ph_addr, ssp_pkg::OFS_BAUD_CONTROL))
            baud_control <= hwdata[7:0];
         if (wr_hit && hit(ph_addr, ssp_pkg::OFS_DIV_LOW))
            divisor[7:0] <= hwdata[7:0];
         if (wr_hit && hit(ph_addr, ssp_pkg::OFS_DIV_HIGH))
            divisor[15:8] <= hwdata[7:0];
         if (wr_hit && hit(ph_addr, ssp_pkg::OFS_IRQ_CTRL))
            irq_ctl <= hwdata[4:0];
         if (wr_tx)
            tx_ctl <= hwdata[7:0];
         if (wr_rx) begin
            rx_ctl <= hwdata[7:0];
         end else if (single_done) begin
            rx_ctl[ssp_pkg::RS_SINGLE] <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // receive shifter and two-deep buffer
   // ------------------------------------------------------------
   logic rx_go;
   logic [3:0] rx_bits;
   assign rx_bits = nine_rx ? ssp_pkg::CHAR_BITS_9 : ssp_pkg::CHAR_BITS_8;
   assign rx_go   = clk_run & rx_mode & ~overrun & (master | rx_ctl[ssp_pkg::RS_CONT]);
   assign rx_done = rx_go & trail & (rx_cnt == rx_bits - 4'h1);
   // single receive ends after one char unless continuous is also set
   assign single_done = rx_done & master & rx_ctl[ssp_pkg::RS_SINGLE];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_shift <= 9'h000;
         rx_cnt   <= 4'h0;
      end else if (!rx_go) begin
         rx_cnt   <= 4'h0;
      end else if (trail) begin
         // lsb first: new bit enters at the top of the character
         rx_shift <= nine_rx ? {data_lvl, rx_shift[8:1]}
                             : {1'b0, data_lvl, rx_shift[7:1]};
         rx_cnt   <= rx_done ? 4'h0 : rx_cnt + 4'h1;
      end
   end

   logic push, clr_ovr;
   logic [8:0] rx_char;
   assign rx_char = nine_rx ? {data_lvl, rx_shift[8:1]} : {1'b0, data_lvl, rx_shift[7:1]};
   assign push    = rx_done & ((fifo_cnt != 2'd2) | rd_data);
   // continuous clear or port disable clears overrun; single mode by read
   assign clr_ovr = ~rx_ctl[ssp_pkg::RS_CONT] & (~port_en | ~rx_ctl[ssp_pkg::RS_SINGLE] | rd_data);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fifo[0]  <= 9'h000;
         fifo[1]  <= 9'h000;
         fifo_cnt <= 2'd0;
         fifo_rd  <= 1'b0;
         overrun  <= 1'b0;
      end else if (!port_en) begin
         fifo_cnt <= 2'd0;
         fifo_rd  <= 1'b0;
         overrun  <= 1'b0;
      end else begin
         if (push)
            fifo[fifo_rd ^ fifo_cnt[0]] <= rx_char;
         if (rd_data)
            fifo_rd <= ~fifo_rd;
         fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, rd_data};
         // set wins over clear in the same cycle
         if (rx_done && fifo_cnt == 2'd2 && !rd_data)
            overrun <= 1'b1;
         else if (clr_ovr)
            overrun <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // transmitter: holding register feeds shift register
   // ------------------------------------------------------------
   logic tx_go, tx_busy, tx_last, load;
   assign tx_go   = clk_run & ~rx_mode & tx_ctl[ssp_pkg::TS_TX_EN];
   assign tx_busy = (tx_cnt != 4'h0);
   assign tx_last = tx_go & trail & (tx_cnt == 4'h1);
   // reload once the previous char is fully out
   assign load    = tx_go & hold_full & (~tx_busy | tx_last);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_hold   <= 9'h000;
         hold_full <= 1'b0;
      end else if (!port_en) begin
         hold_full <= 1'b0;
      end else if (wr_hold) begin
         // ninth bit must already be in place
         tx_hold   <= {tx_ctl[ssp_pkg::TS_NINTH], hwdata[7:0]};
         hold_full <= 1'b1;
      end else if (load) begin
         hold_full <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_shift <= 9'h000;
         tx_cnt   <= 4'h0;
         serial_data_pin_o <= 1'b0;
      end else if (!tx_go) begin
         tx_cnt   <= 4'h0;
      end else if (load) begin
         tx_shift <= tx_hold;
         tx_cnt   <= nine_tx ? ssp_pkg::CHAR_BITS_9 : ssp_pkg::CHAR_BITS_8;
      end else if (lead && tx_busy) begin
         serial_data_pin_o <= tx_shift[0];
         tx_shift <= {1'b0, tx_shift[8:1]};
      end else if (trail && tx_busy) begin
         tx_cnt   <= tx_cnt - 4'h1;
      end
   end
   assign serial_data_pin_oe_n = ~tx_go;

   // holding register empty while tx_go is high is the transmit flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         tx_ready_flag <= 1'b0;
      else
         tx_ready_flag <= tx_go & ~hold_full & ~wr_hold;
   end

   // ------------------------------------------------------------
   // interrupt request and wake
   // ------------------------------------------------------------
   logic rx_flag, rx_req, tx_req;
   assign rx_flag = (fifo_cnt != 2'd0);
   assign rx_req  = rx_flag & irq_ctl[ssp_pkg::IC_RX_IE];
   assign tx_req  = tx_ready_flag & irq_ctl[ssp_pkg::IC_TX_IE];
   assign wake    = (rx_req | tx_req) & irq_ctl[ssp_pkg::IC_PERIPH];
   assign irq     = wake & irq_ctl[ssp_pkg::IC_GLOBAL];

   // ------------------------------------------------------------
   // read mux, combinational from the registered data-phase address
   // ------------------------------------------------------------
   logic [8:0] top;
   assign top = fifo[fifo_rd];
   always_comb begin
      hrdata = 32'h0000_0000;
      unique case (ph_addr)
         ssp_pkg::OFS_BAUD_CONTROL: hrdata[7:0] = baud_control;
         ssp_pkg::OFS_RECEIVE_DATA: hrdata[7:0] = top[7:0];
         ssp_pkg::OFS_RX_STATUS:    hrdata[7:0] = {rx_ctl[7:3], 1'b0, overrun, top[8]};
         ssp_pkg::OFS_DIV_LOW:      hrdata[7:0] = divisor[7:0];
         ssp_pkg::OFS_DIV_HIGH:     hrdata[7:0] = divisor[15:8];
         ssp_pkg::OFS_TX_STATUS:    hrdata[7:0] = {tx_ctl[7:2], ~tx_busy, tx_ctl[0]};
         ssp_pkg::OFS_IRQ_CTRL:     hrdata[4:0] = irq_ctl;
         ssp_pkg::OFS_IRQ_FLAGS:    hrdata[1:0] = {tx_ready_flag, rx_flag};
         default:                   hrdata = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_ovr_keeps;
      @(posedge hclk) disable iff (!hresetn)
      (overrun && port_en && rx_ctl[ssp_pkg::RS_CONT]) |=> overrun;
   endproperty
   a_ovr_keeps: assert property (p_ovr_keeps) else $error("overrun dropped");
   property p_ovr_clear;
      @(posedge hclk) disable iff (!hresetn)
      !port_en |=> !overrun;
   endproperty
   a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");
   property p_fifo_max;
      @(posedge hclk) disable iff (!hresetn) fifo_cnt != 2'd3;
   endproperty
   a_fifo_max: assert property (p_fifo_max) else $error("buffer over two");
   property p_slave_ck;
      @(posedge hclk) disable iff (!hresetn) !master |-> serial_clock_pin_oe_n;
   endproperty
   a_slave_ck: assert property (p_slave_ck) else $error("slave drives clock");
   property p_single;
      @(posedge hclk) disable iff (!hresetn)
      (single_done && !wr_rx) |=> !rx_ctl[ssp_pkg::RS_SINGLE];
   endproperty
   a_single: assert property (p_single) else $error("single not cleared");
   property p_rx_irq;
      @(posedge hclk) disable iff (!hresetn)
      push |=> rx_flag;
   endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("receive flag not set");
   property p_push;
      @(posedge hclk) disable iff (!hresetn)
      (push && !rd_data && port_en) |=> fifo_cnt == $past(fifo_cnt) + 2'd1;
   endproperty
   a_push: assert property (p_push) else $error("char not stored");
   property p_master_sleep;
      @(posedge hclk) disable iff (!hresetn)
      (sleeping && master) |-> (!lead && !trail);
   endproperty
   a_master_sleep: assert property (p_master_sleep) else $error("master shifts in sleep");
endmodule
`default_nettype wire

//--- verif/ssp_far_master.sv
// Purpose: external synchronous master facing the port's slave side
// Assumes: serial clock idles low, 160 ns period, still between frames
// Notes:   the bench starts each frame through the frame task
`default_nettype none
module ssp_far_master (
   output logic      sclk,
   output logic      sdo,
   input  wire logic sdi
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------
   // idle levels from time zero
   // ------------------------------------------------------------
   initial begin
      sclk = 1'h0;
      sdo  = 1'h1;
   end
   // hold the data line at a level while the port clocks it in
   task automatic park(input logic v);
      sdo = v;
   endtask
   // one frame, lsb first; our bit moves after the rising edge, the
   // slave's bit is taken just before the next rise, where it has settled
   task automatic frame(input logic [8:0] tx, input int n, output logic [8:0] rx);
      rx = 9'h000;
      for (int i = 0; i < n; i++) begin
         sclk = 1'h1;
         #20 sdo = tx[i];
         #60 sclk = 1'h0;
         #79 rx[i] = sdi;
         #1;
      end
      // released line never keeps showing the last bit
      #160 sdo = ~sdo;
   endtask
endmodule
`default_nettype wire

//--- verif/sync_serial_rx_and_slave_port_bench.sv
// Purpose: register-level tests of the synchronous serial port
// Assumes: zero wait-state slave, far master model on the serial pins
// Notes:   8-bit registers sit in bits 7:0 of each word
`default_nettype none
module sync_serial_rx_and_slave_port_bench;
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------
   // bus, pins and bookkeeping
   // ------------------------------------------------------------
   logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h1, hwrite = 1'h0;
   logic [7:0]  haddr = 8'h00, rd;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata;
   logic        hreadyout, hresp, ck_o, ck_oe_n, dt_o, dt_oe_n, irq, wake;
   logic        p_ck, p_dt, line;
   logic [8:0]  rx;
   int          err_total = 0, comparisons = 0;
   int          ck_pulses = 0, base;
   always #10 hclk = ~hclk;
   // rising edges of the port's own serial clock
   always @(posedge ck_o) ck_pulses++;
   // data wire: whoever is enabled drives it
   assign line = (dt_oe_n === 1'h0) ? dt_o : p_dt;
   ssp_far_master i_ssp_far_master (.sclk(p_ck), .sdo(p_dt), .sdi(line));
   ssp_sync_port i_ssp_sync_port (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .serial_clock_pin_i(p_ck), .serial_clock_pin_o(ck_o),
      .serial_clock_pin_oe_n(ck_oe_n), .serial_data_pin_i(line),
      .serial_data_pin_o(dt_o), .serial_data_pin_oe_n(dt_oe_n), .irq(irq), .wake(wake));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      if (err_total == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // one single transfer; hready is sampled just before each edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] wd);
      logic ok;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do begin
         @(negedge hclk) ok = hreadyout;
         @(posedge hclk);
      end while (ok !== 1'h1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, wd};
      do begin
         @(negedge hclk) ok = hreadyout;
         rd = hrdata[7:0];
         @(posedge hclk);
      end while (ok !== 1'h1);
   endtask
   // bounded wait for the wake request
   task automatic await_wake;
      for (int i = 0; i < 300 && wake !== 1'h1; i++) @(posedge hclk);
   endtask
   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      // reset values, unmapped place reads zero
      bus(ssp_pkg::OFS_TX_STATUS, 1'h0, 8'h00);
      check("tx_status", rd, ssp_pkg::RST_TX_STATUS);
      bus(8'h3C, 1'h0, 8'h00);
      check("unmapped", rd, ssp_pkg::RST_ZERO);
      // slave receive asleep, single enable set but ignored
      bus(ssp_pkg::OFS_TX_STATUS, 1'h1, 8'h10);
      bus(ssp_pkg::OFS_RX_STATUS, 1'h1, 8'hB0);
      bus(ssp_pkg::OFS_IRQ_CTRL, 1'h1, 8'h15);
      i_ssp_far_master.frame(9'h0A5, 8, rx);
      await_wake;
      check("wake", wake, 1'h1);
      check("irq_no_global", irq, 1'h0);
      check("clk_oe_n", ck_oe_n, 1'h1);
      bus(ssp_pkg::OFS_IRQ_FLAGS, 1'h0, 8'h00);
      check("rx_flag", rd[ssp_pkg::IF_RX], 1'h1);
      bus(ssp_pkg::OFS_RECEIVE_DATA, 1'h0, 8'h00);
      check("rx_data", rd, 8'hA5);
      // nine-bit character, status read before data
      bus(ssp_pkg::OFS_RX_STATUS, 1'h1, 8'hD0);
      i_ssp_far_master.frame(9'h15A, 9, rx);
      bus(ssp_pkg::OFS_RX_STATUS, 1'h0, 8'h00);
      check("ninth", rd[ssp_pkg::RS_NINTH], 1'h1);
      bus(ssp_pkg::OFS_RECEIVE_DATA, 1'h0, 8'h00);
      check("rx_data9", rd, 8'h5A);
      // third character with the buffer full
      bus(ssp_pkg::OFS_RX_STATUS, 1'h1, 8'h90);
      for (int i = 1; i < 4; i++) i_ssp_far_master.frame(9'(i * 17), 8, rx);
      bus(ssp_pkg::OFS_RX_STATUS, 1'h0, 8'h00);
      check("overrun", rd[ssp_pkg::RS_OVERRUN], 1'h1);
      bus(ssp_pkg::OFS_RECEIVE_DATA, 1'h0, 8'h00);
      check("kept_first", rd, 8'h11);
      bus(ssp_pkg::OFS_RX_STATUS, 1'h1, 8'h80);
      bus(ssp_pkg::OFS_RX_STATUS, 1'h0, 8'h00);
      check("overrun_clear", rd[ssp_pkg::RS_OVERRUN], 1'h0);
      // slave transmit of two characters while asleep
      bus(ssp_pkg::OFS_TX_STATUS, 1'h1, 8'h30);
      bus(ssp_pkg::OFS_IRQ_CTRL, 1'h1, 8'h1E);
      bus(ssp_pkg::OFS_TX_HOLDING, 1'h1, 8'hC3);
      bus(ssp_pkg::OFS_TX_HOLDING, 1'h1, 8'h3C);
      bus(ssp_pkg::OFS_IRQ_FLAGS, 1'h0, 8'h00);
      check("tx_flag_held", rd[ssp_pkg::IF_TX], 1'h0);
      check("dt_oe_n", dt_oe_n, 1'h0);
      i_ssp_far_master.frame(9'h000, 8, rx);
      check("tx_first", rx[7:0], 8'hC3);
      await_wake;
      check("tx_irq", irq, 1'h1);
      bus(ssp_pkg::OFS_IRQ_FLAGS, 1'h0, 8'h00);
      check("tx_flag", rd[ssp_pkg::IF_TX], 1'h1);
      i_ssp_far_master.frame(9'h000, 8, rx);
      check("tx_second", rx[7:0], 8'h3C);
      // nine-bit slave transmit: low eight first, then the ninth bit
      bus(ssp_pkg::OFS_TX_STATUS, 1'h1, 8'h71);
      bus(ssp_pkg::OFS_TX_HOLDING, 1'h1, 8'h96);
      i_ssp_far_master.frame(9'h000, 9, rx);
      check("tx_nine", rx, 9'h196);
      // port disable empties the buffer and clears the receive flag
      bus(ssp_pkg::OFS_RX_STATUS, 1'h1, 8'h00);
      bus(ssp_pkg::OFS_IRQ_FLAGS, 1'h0, 8'h00);
      check("rx_flag_off", rd[ssp_pkg::IF_RX], 1'h0);
      // single master receive, held off while asleep
      bus(ssp_pkg::OFS_DIV_LOW, 1'h1, 8'h03);
      bus(ssp_pkg::OFS_TX_STATUS, 1'h1, 8'h90);
      bus(ssp_pkg::OFS_IRQ_CTRL, 1'h1, 8'h10);
      i_ssp_far_master.park(1'h1);
      base = ck_pulses;
      bus(ssp_pkg::OFS_RX_STATUS, 1'h1, 8'hA0);
      repeat (100) @(posedge hclk);
      check("sleep_clocks", 9'(ck_pulses - base), 9'h000);
      bus(ssp_pkg::OFS_IRQ_CTRL, 1'h1, 8'h00);
      rd = 8'hFF;
      for (int i = 0; i < 200 && rd[ssp_pkg::RS_SINGLE]; i++)
         bus(ssp_pkg::OFS_RX_STATUS, 1'h0, 8'h00);
      check("single_clear", rd[ssp_pkg::RS_SINGLE], 1'h0);
      check("m_clocks", 9'(ck_pulses - base), 9'h008);
      check("m_clk_oe_n", ck_oe_n, 1'h0);
      bus(ssp_pkg::OFS_RECEIVE_DATA, 1'h0, 8'h00);
      check("m_rx_data", rd, 8'hFF);
      complete_run;
   end
   // watchdog well beyond the eight frames above
   initial begin
      #200000;
      err_total++;
      complete_run;
   end
endmodule
`default_nettype wire
